// [logic/srs_top.sv]
// Purpose: automatic synchronization reference selection and timing
// Assumes: config and defect flags come from pins, status bytes on lineClk
// Notes: selection changes take effect only at a frame boundary
//
// How it works
// RULE1 - pick source by defect, quality, priority
// RULE2 - best quality set, then highest priority
// RULE3 - each input has quality, unique priority
// RULE4 - quality 15 input is never chosen
// RULE5 - line status taken from section status byte
// RULE6 - tributary designatable regardless of traffic
// RULE7 - internal oscillator is a selectable candidate
// RULE8 - separate system and output selections
// RULE9 - deliver timing clock plus frame start
// RULE10 - connection functions build unequipped containers
// RULE11 - sink functions pass input timing through
// RULE12 - sinks may gap clock over overhead
// RULE13 - aligning sinks output recovered frame start
// RULE14 - smoothing adaptations output evenly spaced clock
// RULE15 - adaptation sources use distributed timing pair
// RULE16 - termination sources use access point timing
// RULE17 - sink alarm fill uses input clock
// RULE18 - source alarm fill uses layer timing clock
// RULE19 - section alarm fill uses 20 ppm oscillator
// RULE20 - tributary alarm fill oscillators per rate; only the section alarm oscillator is modelled
// RULE21 - all externals bad: internal, flag it
// RULE22 - switch bounded in time, frame start clean
`timescale 1ns/100ps

// ==================================================================
// top
module srs_top #(
  parameter int FrameCycles = srs_pkg::FRAME_CYCLES
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lineClk,
  // line status bytes, on lineClk
  input wire logic [srs_pkg::NUM_LINE-1:0][7:0] lineS1Byte,
  input wire logic [srs_pkg::NUM_LINE-1:0] lineS1Valid,
  // reference defects, asynchronous pins
  input wire logic [srs_pkg::NUM_EXT-1:0] refDefect,
  // configuration, asynchronous pins
  input wire srs_pkg::srs_privec_t refPriority,
  input wire logic [srs_pkg::NUM_REF-1:0] sysEnable,
  input wire logic [srs_pkg::NUM_REF-1:0] outEnable,
  input wire logic [srs_pkg::NUM_TRIB-1:0] tribDesignate,
  input wire logic [srs_pkg::NUM_TRIB-1:0][srs_pkg::QL_W-1:0] tribQuality,
  input wire srs_pkg::srs_ql_t stationQuality,
  // selection status
  output srs_pkg::srs_ref_t sysRefSel,
  output srs_pkg::srs_ref_t outRefSel,
  output srs_pkg::srs_ql_t sysRefQuality,
  output srs_pkg::srs_ql_t outRefQuality,
  output logic holdover,
  output logic priorityConflict,
  // distributed timing
  output logic timingClock,
  output logic timingFrameStart
);
  import srs_pkg::*;

  localparam logic [FCNT_W-1:0] FRAME_LAST = FCNT_W'(FrameCycles - 1);
  localparam logic [FCNT_W-1:0] TCK_LAST = FCNT_W'(TCK_HALF_CYCLES - 1);

  // ================================================================
  // selection function, used by both selectors
  function automatic srs_ref_t pickRef(input logic [NUM_REF-1:0] elig,
                                       input srs_qlvec_t ql,
                                       input srs_privec_t pri);
    srs_ref_t best;
    srs_ql_t bestQl;
    srs_pri_t bestPri;
    best = IDX_INTERNAL;
    bestQl = ql[IDX_INTERNAL];
    bestPri = pri[IDX_INTERNAL];
    for (int i = 0; i < NUM_REF; i++) begin
      if (elig[i] && ((ql[i] < bestQl) || // RULE2
          ((ql[i] == bestQl) && (pri[i] < bestPri)))) begin
        best = REF_W'(i);
        bestQl = ql[i];
        bestPri = pri[i];
      end
    end
    return best;
  endfunction

  function automatic logic dupPriority(input srs_privec_t pri);
    logic dup;
    dup = 1'b0;
    for (int i = 0; i < NUM_REF; i++) begin
      for (int j = i + 1; j < NUM_REF; j++) begin
        if (pri[i] == pri[j]) begin
          dup = 1'b1;
        end
      end
    end
    return dup;
  endfunction

  // ================================================================
  // pin synchronizers
  logic [NUM_EXT-1:0] defSync1;
  logic [NUM_EXT-1:0] defSync2;
  srs_privec_t priSync1;
  srs_privec_t priSync2;
  logic [NUM_REF-1:0] sysEnSync1;
  logic [NUM_REF-1:0] sysEnSync2;
  logic [NUM_REF-1:0] outEnSync1;
  logic [NUM_REF-1:0] outEnSync2;
  logic [NUM_TRIB-1:0] desSync1;
  logic [NUM_TRIB-1:0] desSync2;
  logic [NUM_TRIB-1:0][QL_W-1:0] tribQlSync1;
  logic [NUM_TRIB-1:0][QL_W-1:0] tribQlSync2;
  srs_ql_t stnQlSync1;
  srs_ql_t stnQlSync2;

  // multi-bit config may be torn for one cycle; besides a possible priorityConflict pulse it only shifts a choice
  // that is not applied before the next frame boundary anyway
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      defSync1 <= '1;
      defSync2 <= '1;
      priSync1 <= {NUM_REF{PRI_RESET}};
      priSync2 <= {NUM_REF{PRI_RESET}};
      sysEnSync1 <= '0;
      sysEnSync2 <= '0;
      outEnSync1 <= '0;
      outEnSync2 <= '0;
      desSync1 <= '0;
      desSync2 <= '0;
      tribQlSync1 <= {NUM_TRIB{QL_DO_NOT_USE}};
      tribQlSync2 <= {NUM_TRIB{QL_DO_NOT_USE}};
      stnQlSync1 <= QL_DO_NOT_USE;
      stnQlSync2 <= QL_DO_NOT_USE;
    end else begin
      defSync1 <= refDefect;
      defSync2 <= defSync1;
      priSync1 <= refPriority;
      priSync2 <= priSync1;
      sysEnSync1 <= sysEnable;
      sysEnSync2 <= sysEnSync1;
      outEnSync1 <= outEnable;
      outEnSync2 <= outEnSync1;
      desSync1 <= tribDesignate;
      desSync2 <= desSync1;
      tribQlSync1 <= tribQuality;
      tribQlSync2 <= tribQlSync1;
      stnQlSync1 <= stationQuality;
      stnQlSync2 <= stnQlSync1;
    end
  end

  // ================================================================
  // quality collection
  logic [NUM_LINE-1:0][QL_W-1:0] lineQl;

  for (genvar g = 0; g < NUM_LINE; g++) begin : gLine
    srs_s1_capture uCap (
      .lineClk(lineClk),
      .clk(clk),
      .rst_n(rst_n),
      .s1Byte(lineS1Byte[g]),
      .s1Valid(lineS1Valid[g]),
      .quality(lineQl[g])
    );
  end

  srs_qlvec_t refQl;
  logic [NUM_REF-1:0] baseOk;
  logic [NUM_REF-1:0] sysElig;
  logic [NUM_REF-1:0] outElig;

  always_comb begin
    refQl = '0;
    baseOk = '0;
    for (int i = 0; i < NUM_LINE; i++) begin
      refQl[i] = lineQl[i]; // RULE3
    end
    for (int i = 0; i < NUM_TRIB; i++) begin
      refQl[FIRST_TRIB+i] = tribQlSync2[i];
    end
    refQl[FIRST_STN] = stnQlSync2;
    refQl[IDX_INTERNAL] = QL_INTERNAL; // RULE7
    for (int i = 0; i < NUM_EXT; i++) begin
      // all-ones alone is enough to exclude, no separate fail needed
      baseOk[i] = !defSync2[i] && (refQl[i] != QL_DO_NOT_USE); // RULE1 RULE4
    end
    for (int i = 0; i < NUM_TRIB; i++) begin
      // traffic state is not looked at, only the designation
      baseOk[FIRST_TRIB+i] = baseOk[FIRST_TRIB+i] && desSync2[i]; // RULE6
    end
    baseOk[IDX_INTERNAL] = 1'b1; // RULE7
  end

  assign sysElig = baseOk & (sysEnSync2 | (NUM_REF'(1) << IDX_INTERNAL));
  assign outElig = baseOk & (outEnSync2 | (NUM_REF'(1) << IDX_INTERNAL));

  // ================================================================
  // two independent selections
  srs_ref_t pendingSys;
  srs_ref_t pendingOut;
  logic allExtBad;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendingSys <= IDX_INTERNAL;
      pendingOut <= IDX_INTERNAL;
      allExtBad <= 1'b1;
    end else begin
      pendingSys <= pickRef(sysElig, refQl, priSync2); // RULE1 RULE8
      pendingOut <= pickRef(outElig, refQl, priSync2); // RULE8
      allExtBad <= ~|sysElig[NUM_EXT-1:0]; // RULE21
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      priorityConflict <= 1'b0;
    end else begin
      // equal priorities: lower index wins among externals, the internal input wins its own ties, and software is told
      priorityConflict <= dupPriority(priSync2); // RULE3
    end
  end

  // ================================================================
  // frame and clock generation
  logic [FCNT_W-1:0] frameCnt;
  logic [FCNT_W-1:0] tckCnt;
  logic frameWrap;

  assign frameWrap = frameCnt == FRAME_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCnt <= '0;
      timingFrameStart <= 1'b0;
    end else begin
      frameCnt <= frameWrap ? '0 : frameCnt + FCNT_W'(1);
      timingFrameStart <= frameWrap; // RULE9 RULE15
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tckCnt <= '0;
      timingClock <= 1'b0;
    end else if (tckCnt == TCK_LAST) begin
      tckCnt <= '0;
      timingClock <= ~timingClock; // RULE9 RULE10
    end else begin
      tckCnt <= tckCnt + FCNT_W'(1);
    end
  end

  // ================================================================
  // apply selections at frame boundary
  // frame start never moves, so a switch cannot clip or double it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysRefSel <= IDX_INTERNAL;
      outRefSel <= IDX_INTERNAL;
      sysRefQuality <= QL_INTERNAL;
      outRefQuality <= QL_INTERNAL;
      holdover <= 1'b1;
    end else if (frameWrap) begin
      sysRefSel <= pendingSys; // RULE22
      outRefSel <= pendingOut; // RULE8
      sysRefQuality <= refQl[pendingSys];
      outRefQuality <= refQl[pendingOut];
      holdover <= allExtBad; // RULE21
    end
  end

  // ================================================================
  // checks
  logic [FCNT_W-1:0] swWait;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swWait <= '0;
    end else if (pendingSys != sysRefSel) begin
      swWait <= swWait + FCNT_W'(1);
    end else begin
      swWait <= '0;
    end
  end

  sequence seqFsPulse;
    timingFrameStart ##1 !timingFrameStart;
  endsequence

  sequence seqFsQuiet;
    !timingFrameStart [*8];
  endsequence

  AST_ELIGIBLE_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    $past(sysElig) != '0 |-> (($past(sysElig) >> pendingSys) & NUM_REF'(1)) != '0)
    else $error("system selection points at an ineligible input");

  AST_BEST_QUALITY: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    $past(sysElig[FIRST_STN]) && pendingSys != IDX_INTERNAL |->
    QL_W'($past(refQl) >> (pendingSys * QL_W)) <= $past(refQl[FIRST_STN]))
    else $error("selected input has worse quality than an eligible one");

  AST_DNU_EXCLUDED: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    pendingSys != IDX_INTERNAL |-> QL_W'($past(refQl) >> (pendingSys * QL_W)) != QL_DO_NOT_USE)
    else $error("quality 15 input was selected");

  AST_UNDESIGNATED: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    !$past(desSync2[0]) |-> pendingSys != REF_W'(FIRST_TRIB))
    else $error("undesignated tributary was selected");

  AST_PRI_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    $past(rst_n) && $past(priSync2[FIRST_TRIB]) == $past(priSync2[FIRST_TRIB + 1]) |->
    priorityConflict)
    else $error("shared priority not flagged");

  AST_FALLBACK: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    holdover |-> sysRefSel == IDX_INTERNAL)
    else $error("holdover flagged while an external input is in use");

  AST_OUT_SEL: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    $changed(outRefSel) |-> $past(frameWrap) && outRefSel == $past(pendingOut))
    else $error("output selection changed off a frame boundary");

  AST_FS_SHAPE: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    seqFsPulse |-> seqFsQuiet)
    else $error("frame start pulses too close together");

  AST_SWITCH_AT_FRAME: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
    $changed(sysRefSel) |-> $past(frameWrap) && $past(timingFrameStart, 1) == 1'b0)
    else $error("system selection changed off a frame boundary");

  AST_SWITCH_BOUND: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
    swWait <= FCNT_W'(FrameCycles))
    else $error("selection switch took longer than one frame");
endmodule

// [logic/srs_pkg.sv]
// Purpose: shared constants and types for the reference selector
// Assumes: lower quality code is better, 15 means do not use
// Notes: timing counts derive from the 100 MHz system clock

// ==================================================================
// package
package srs_pkg;
  localparam int NUM_LINE = 2;
  localparam int NUM_TRIB = 2;
  localparam int NUM_STN = 1;
  localparam int NUM_REF = NUM_LINE + NUM_TRIB + NUM_STN + 1;
  localparam int NUM_EXT = NUM_REF - 1;
  localparam int REF_W = 3;
  localparam int QL_W = 4;
  localparam int PRI_W = 3;
  localparam int FIRST_TRIB = NUM_LINE;
  localparam int FIRST_STN = NUM_LINE + NUM_TRIB;
  localparam logic [REF_W-1:0] IDX_INTERNAL = 3'h5;
  // quality carried in the low nibble of the section status byte
  localparam int SSM_LSB = 0;
  localparam int SSM_MSB = 3;
  localparam logic [QL_W-1:0] QL_DO_NOT_USE = 4'hF;
  localparam logic [QL_W-1:0] QL_INTERNAL = 4'hB;
  localparam logic [PRI_W-1:0] PRI_RESET = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_TIME_NS = 125000;
  localparam int FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int TCK_HALF_NS = 20;
  localparam int TCK_HALF_CYCLES = TCK_HALF_NS / CLK_PERIOD_NS;
  localparam int FCNT_W = 16;

  typedef logic [QL_W-1:0] srs_ql_t;
  typedef logic [PRI_W-1:0] srs_pri_t;
  typedef logic [REF_W-1:0] srs_ref_t;
  typedef logic [NUM_REF-1:0][QL_W-1:0] srs_qlvec_t;
  typedef logic [NUM_REF-1:0][PRI_W-1:0] srs_privec_t;
endpackage

// [logic/srs_s1_capture.sv]
// Purpose: take the status nibble on the line clock, hand it to clk
// Assumes: status bytes come far slower than the handshake round trip
// Notes: bytes offered while a handoff is in flight are dropped
`timescale 1ns/100ps

// ==================================================================
// status byte capture and crossing
module srs_s1_capture (
  // clocks and reset
  input wire logic lineClk,
  input wire logic clk,
  input wire logic rst_n,
  // line side
  input wire logic [7:0] s1Byte,
  input wire logic s1Valid,
  // system side
  output srs_pkg::srs_ql_t quality
);
  import srs_pkg::*;

  srs_ql_t holdQl;
  logic req;
  logic ackSync1;
  logic ackSync2;
  logic reqSync1;
  logic reqSync2;
  logic reqSeen;
  logic busy;

  assign busy = req != ackSync2;

  // ================================================================
  // line domain
  always_ff @(posedge lineClk or negedge rst_n) begin
    if (!rst_n) begin
      holdQl <= QL_DO_NOT_USE;
      req <= 1'b0;
    end else if (s1Valid && !busy) begin
      // all-ones after an upstream defect reads as 15 here
      holdQl <= s1Byte[SSM_MSB:SSM_LSB]; // RULE5 RULE4
      req <= ~req;
    end
  end

  always_ff @(posedge lineClk or negedge rst_n) begin
    if (!rst_n) begin
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
    end else begin
      ackSync1 <= reqSeen;
      ackSync2 <= ackSync1;
    end
  end

  // ================================================================
  // system domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync1 <= 1'b0;
      reqSync2 <= 1'b0;
    end else begin
      reqSync1 <= req;
      reqSync2 <= reqSync1;
    end
  end

  // holdQl is stable while req and ack differ, so a plain load is safe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSeen <= 1'b0;
      quality <= QL_DO_NOT_USE;
    end else if (reqSync2 != reqSeen) begin
      reqSeen <= reqSync2;
      quality <= holdQl; // RULE5
    end
  end

  AST_S1_HANDOFF: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    $changed(reqSync2) |=> (quality == holdQl) && (reqSeen == reqSync2))
    else $error("status nibble not handed to system side");
endmodule

// [tb/srs_line_partner.sv]
// Purpose: line side model sending section status bytes on lineClk
// Assumes: line clock runs free, bytes spaced well apart
// Notes: byte lanes show the inverse of the last byte when not valid
`timescale 1ns/100ps

// ==================================================================
// line partner
module srs_line_partner (
  // link clock
  input wire logic lineClk,
  // status bytes toward the block
  output logic [srs_pkg::NUM_LINE-1:0][7:0] lineS1Byte,
  output logic [srs_pkg::NUM_LINE-1:0] lineS1Valid
);
  import srs_pkg::*;

  initial begin
    lineS1Byte = '0;
    lineS1Valid = '0;
  end

  // one byte, one lineClk valid pulse, then a quiet gap
  task automatic send(input int idx, input logic [7:0] b);
    @(posedge lineClk);
    lineS1Byte[idx] <= b;
    lineS1Valid[idx] <= 1'b1;
    @(posedge lineClk);
    lineS1Valid[idx] <= 1'b0;
    lineS1Byte[idx] <= ~b;
    // gap keeps us clear of a handoff still in flight
    repeat (4) @(posedge lineClk);
  endtask
endmodule

// ==================================================================
// timing consumer partner
module srs_timing_partner #(
  parameter int OhTicks = 3
) (
  // distributed timing from the block
  input wire logic clk,
  input wire logic timingClock,
  input wire logic timingFrameStart,
  // timing as the modelled functions use it
  output logic sinkClk,
  output logic sinkFs,
  output logic alignFs,
  output logic smoothClk,
  output logic sectionAisClk,
  output int srcReads,
  output int unequippedCnt
);
  import srs_pkg::*;

  // marker value is arbitrary
  localparam logic [7:0] FRAME_MARK = 8'h5A;

  logic prevTck;
  logic lastMark;
  logic [7:0] adaptedData;
  int ohCnt;
  int smCnt;

  initial begin
    prevTck = 1'b0;
    lastMark = 1'b0;
    adaptedData = 8'h00;
    ohCnt = 0;
    smCnt = 0;
    alignFs = 1'b0;
    smoothClk = 1'b0;
    srcReads = 0;
    unequippedCnt = 0;
  end

  // sinks pass input timing on; sink alarm fill runs on this clock
  assign sinkFs = timingFrameStart;
  assign sinkClk = timingClock && (ohCnt == 0);

  // own alarm oscillator, free of block timing; ppm offsets not modelled
  initial begin
    sectionAisClk = 1'b0;
    forever #37.5 sectionAisClk = ~sectionAisClk;
  end

  always @(posedge clk) begin
    prevTck <= timingClock;
    lastMark <= adaptedData == FRAME_MARK;
    // aligning sink recovers frame start from the data, not from fs
    alignFs <= (adaptedData == FRAME_MARK) && !lastMark;
    if (timingFrameStart) begin
      ohCnt <= OhTicks;
      adaptedData <= FRAME_MARK;
      unequippedCnt <= unequippedCnt + 1;
    end else if (timingClock && !prevTck) begin
      adaptedData <= adaptedData + 8'h01;
    end else if (!timingClock && prevTck && ohCnt > 0) begin
      // gap ends on a fall, so no runt pulse leaks out
      ohCnt <= ohCnt - 1;
    end
    if (timingClock && !prevTck) begin
      // source, termination source and source alarm fill share this clock
      srcReads <= srcReads + 1;
    end
    if (smCnt == TCK_HALF_CYCLES - 1) begin
      smCnt <= 0;
      smoothClk <= ~smoothClk;
    end else begin
      smCnt <= smCnt + 1;
    end
  end
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench for the reference selector
// Assumes: short frame parameter, line partner on its own clock
// Notes: selections are judged after a frame boundary, except the reset state check
`timescale 1ns/100ps

// ==================================================================
// bench top
module tb;
  import srs_pkg::*;
  localparam int FC = 40;
  localparam int OH_TICKS = 3;

  logic clk, rst_n, lineClk;
  logic [NUM_LINE-1:0][7:0] lineS1Byte;
  logic [NUM_LINE-1:0] lineS1Valid;
  logic [NUM_EXT-1:0] refDefect;
  srs_privec_t refPriority;
  logic [NUM_REF-1:0] sysEnable, outEnable;
  logic [NUM_TRIB-1:0] tribDesignate;
  logic [NUM_TRIB-1:0][QL_W-1:0] tribQuality;
  srs_ql_t stationQuality, sysRefQuality, outRefQuality;
  srs_ref_t sysRefSel, outRefSel;
  logic holdover, priorityConflict, timingClock, timingFrameStart;
  logic sinkClk, sinkFs, alignFs, smoothClk, sectionAisClk;
  int srcReads, unequippedCnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  srs_top #(.FrameCycles(FC)) dut_u (.clk(clk), .rst_n(rst_n), .lineClk(lineClk),
    .lineS1Byte(lineS1Byte), .lineS1Valid(lineS1Valid), .refDefect(refDefect),
    .refPriority(refPriority), .sysEnable(sysEnable), .outEnable(outEnable),
    .tribDesignate(tribDesignate), .tribQuality(tribQuality),
    .stationQuality(stationQuality), .sysRefSel(sysRefSel), .outRefSel(outRefSel),
    .sysRefQuality(sysRefQuality), .outRefQuality(outRefQuality), .holdover(holdover),
    .priorityConflict(priorityConflict), .timingClock(timingClock),
    .timingFrameStart(timingFrameStart));

  srs_line_partner line_u (.lineClk(lineClk), .lineS1Byte(lineS1Byte),
    .lineS1Valid(lineS1Valid));

  srs_timing_partner #(.OhTicks(OH_TICKS)) time_u (.clk(clk), .timingClock(timingClock),
    .timingFrameStart(timingFrameStart), .sinkClk(sinkClk), .sinkFs(sinkFs),
    .alignFs(alignFs), .smoothClk(smoothClk), .sectionAisClk(sectionAisClk),
    .srcReads(srcReads), .unequippedCnt(unequippedCnt));

  // ==================================================================
  // clocks and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    // phase offset keeps the two clocks unrelated
    lineClk = 1'b0;
    #3.7;
    forever #62.5 lineClk = ~lineClk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==================================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_frame(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        tick();
        k++;
      end while (timingFrameStart !== 1'b1 && k < 200);
      if (k >= 200) check(16'h0, 16'h1, "frame start missing");
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic expect_sel(input srs_ref_t r, input srs_ql_t q, input logic h, input string m);
    check(16'(sysRefSel), 16'(r), m);
    check(16'(sysRefQuality), 16'(q), m);
    check(16'(holdover), 16'(h), m);
  endtask

  // ==================================================================
  // scenarios
  task automatic s_timing();
    int n;
    wait_frame(1);
    n = 0;
    do begin
      tick();
      n++;
    end while (timingFrameStart !== 1'b1 && n < 200);
    check(16'(n), 16'(FC), "frame start spacing");
    // start from a low phase so the whole high time is counted
    n = 0;
    while (timingClock === 1'b1 && n < 10) begin
      tick();
      n++;
    end
    n = 0;
    while (timingClock !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    n = 0;
    while (timingClock === 1'b1 && n < 10) begin
      tick();
      n++;
    end
    check(16'(n), 16'(TCK_HALF_CYCLES), "timing clock high time");
  endtask

  task automatic s_partner();
    int r0, u0, n, rises, aligns, smooth, ais;
    logic lastSink, lastSmooth, lastAis;
    wait_frame(1);
    check(16'(sinkFs), 16'h1, "sink frame start passed on");
    r0 = srcReads;
    u0 = unequippedCnt;
    n = 0;
    rises = 0;
    aligns = 0;
    smooth = 0;
    ais = 0;
    do begin
      lastSink = sinkClk;
      lastSmooth = smoothClk;
      lastAis = sectionAisClk;
      tick();
      n++;
      if (sinkClk && !lastSink) rises++;
      if (smoothClk && !lastSmooth) smooth++;
      if (sectionAisClk && !lastAis) ais++;
      if (alignFs) aligns++;
    end while (timingFrameStart !== 1'b1 && n < 200);
    check(16'(srcReads - r0), 16'(FC / (2 * TCK_HALF_CYCLES)), "source reads");
    check(16'(unequippedCnt - u0), 16'h1, "unequipped frames");
    check(16'(rises), 16'(FC / (2 * TCK_HALF_CYCLES) - OH_TICKS), "gapped clock");
    check(16'(aligns), 16'h1, "recovered frame start");
    check(16'(smooth), 16'(FC / (2 * TCK_HALF_CYCLES)), "smoothed clock");
    check(16'(ais != 0), 16'h1, "alarm oscillator running");
  endtask

  task automatic s_quality();
    // high nibble must be ignored
    line_u.send(0, 8'hA2);
    line_u.send(1, 8'h53);
    wait_frame(2);
    expect_sel(3'h0, 4'h2, 1'b0, "best line quality");
    check(16'(outRefSel), 16'h0, "output selection");
    line_u.send(1, 8'h01);
    wait_frame(2);
    expect_sel(3'h1, 4'h1, 1'b0, "quality before priority");
  endtask

  task automatic s_priority();
    line_u.send(0, 8'h01);
    wait_frame(2);
    expect_sel(3'h0, 4'h1, 1'b0, "tie broken by priority");
    @(posedge clk);
    refPriority[0] <= 3'h1;
    refPriority[1] <= 3'h0;
    wait_frame(2);
    expect_sel(3'h1, 4'h1, 1'b0, "priority swap");
    check(16'(priorityConflict), 16'h0, "no conflict");
  endtask

  task automatic s_all_ones();
    line_u.send(1, 8'hFF);
    wait_frame(2);
    expect_sel(3'h0, 4'h1, 1'b0, "all ones excluded");
  endtask

  task automatic s_fallback();
    @(posedge clk);
    refDefect[0] <= 1'b1;
    wait_frame(2);
    expect_sel(IDX_INTERNAL, QL_INTERNAL, 1'b1, "internal fallback");
    check(16'(outRefSel), 16'(IDX_INTERNAL), "output on internal");
  endtask

  task automatic s_trib();
    @(posedge clk);
    tribQuality[0] <= 4'h4;
    tribDesignate[0] <= 1'b1;
    outEnable[2] <= 1'b0;
    // station usable but worse than the tributary, kept off the output side
    stationQuality <= 4'h6;
    outEnable[4] <= 1'b0;
    wait_frame(2);
    expect_sel(3'h2, 4'h4, 1'b0, "designated tributary");
    check(16'(outRefSel), 16'(IDX_INTERNAL), "output own mask");
    check(16'(outRefQuality), 16'(QL_INTERNAL), "output quality");
  endtask

  task automatic s_conflict();
    @(posedge clk);
    refPriority[3] <= refPriority[2];
    repeat (8) tick();
    check(16'(priorityConflict), 16'h1, "shared priority");
  endtask

  // ==================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    refDefect = '0;
    refPriority = {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    sysEnable = '1;
    outEnable = '1;
    tribDesignate = '0;
    tribQuality = {4'hF, 4'hF};
    stationQuality = 4'hF;
    repeat (8) @(posedge clk);
    #1;
    expect_sel(IDX_INTERNAL, QL_INTERNAL, 1'b1, "reset state");
    check(16'(timingFrameStart), 16'h0, "reset frame start");
    @(posedge clk);
    rst_n <= 1'b1;
    s_timing();
    s_partner();
    s_quality();
    s_priority();
    s_all_ones();
    s_fallback();
    s_trib();
    s_conflict();
    finish_test();
  end
endmodule
